// ==== core/mcst_pkg.sv ====
package mcst_pkg;
   // clock and timing figures
   localparam int unsigned CLK_MHZ = 20;
   localparam int unsigned RST_MIN_NS = 2000;
   localparam int unsigned RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RST_CNT_W = 6;
   localparam int unsigned INIT_MS = 2000;
   localparam int unsigned INIT_CYC_DOC = INIT_MS * CLK_MHZ * 1000;
   localparam int unsigned INIT_W = 26;

   // synchroniser lane positions
   localparam int unsigned SYN_W = 10;
   localparam int unsigned SI_SCL = 0;
   localparam int unsigned SI_SDA = 1;
   localparam int unsigned SI_SEL = 2;
   localparam int unsigned SI_RST = 3;
   localparam int unsigned SI_LP = 4;
   localparam int unsigned SI_TXF = 5;
   localparam int unsigned SI_LOS = 6;
   localparam logic [SYN_W-1:0] SYN_RST_VAL = 10'h00F;

   // 2-wire byte map
   localparam logic [7:0] RA_STATUS = 8'h02;
   localparam logic [7:0] RA_FLAGS = 8'h03;
   localparam logic [7:0] RA_MASK = 8'h04;
   localparam logic [7:0] RA_CTRL = 8'h05;
   localparam int unsigned NOT_READY_BIT = 0;
   localparam int unsigned PDOWN_BIT = 0;
   localparam logic [6:0] DEV_ADDR_DEF = 7'h50;
   localparam logic [6:0] MASK_RST = 7'h00;
   localparam logic PDOWN_RST = 1'b0;
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // apb map
   localparam logic [7:0] APB_STATUS = 8'h00;
   localparam logic [7:0] APB_EVENT = 8'h04;
   localparam int unsigned EV_OTHER_BIT = 0;
   localparam int unsigned ST_NRDY_LSB = 0;
   localparam int unsigned ST_LP_LSB = 1;
   localparam int unsigned ST_FLAG_LSB = 8;
   localparam int unsigned ST_MASK_LSB = 16;

   typedef struct packed {
      logic init_done;
      logic other;
      logic tx_fault;
      logic [3:0] los;
   } mcst_flags_s;

   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_AACK, S_WR, S_WACK, S_RD, S_RACK
   } mcst_tw_e;
endpackage : mcst_pkg

// ==== core/mcst_sync.sv ====
`timescale 1ns/1ps
module mcst_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;
endmodule : mcst_sync

// ==== core/mcst_timer.sv ====
`timescale 1ns/1ps
module mcst_timer #(
   parameter int unsigned W = 26,
   parameter logic [W-1:0] LOAD = '1
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic start_i,
   output logic done_o
);
   logic [W-1:0] cnt_q;
   logic done_q;
   localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

   // runs from reset so power-up needs no start pulse
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= LOAD;
      end else if (start_i) begin
         cnt_q <= LOAD;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - ONE;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         done_q <= 1'b0;
      end else begin
         done_q <= !start_i && (cnt_q == ONE);
      end
   end

   assign done_o = done_q;
endmodule : mcst_timer

// ==== core/mcst_top.sv ====
`timescale 1ns/1ps
module mcst_top
   import mcst_pkg::*;
#(
   parameter int unsigned INIT_CYC = INIT_CYC_DOC,
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
   input wire logic MCLK_I,
   input wire logic ARST_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_O,
   input wire logic MODULE_SELECT_N_I,
   input wire logic MODULE_RESET_N_I,
   input wire logic LOW_POWER_REQUEST_I,
   input wire logic [3:0] RX_LOS_I,
   input wire logic TX_FAULT_I,
   output logic INTERRUPT_OUT_N_O,
   output logic PRESENCE_OUT_N_O,
   output logic LOW_POWER_O
);
   logic [SYN_W-1:0] s;
   logic scl_p_q, sda_p_q;
   logic scl_rise, scl_fall, start_c, stop_c, sel;
   logic [RST_CNT_W-1:0] lo_cnt_q;
   logic soft_rst, init_done;
   logic not_ready_q;
   mcst_flags_s flags_q, flag_set, flag_clr;
   logic [3:0] los_p_q;
   logic txf_p_q;
   logic [6:0] mask_q;
   logic pdown_q;
   mcst_tw_e st_q;
   logic [7:0] sh_q, ptr_q;
   logic [3:0] bit_q;
   logic first_q, rw_q, nack_q, oe_q;
   logic wr_stb, rd_done;
   logic int_n_q, lp_q, zero_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic ev_stb;
   logic [7:0] rd_byte;

   function automatic logic [7:0] reg_rd(input logic [7:0] a);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         RA_STATUS: r[NOT_READY_BIT] = not_ready_q;
         RA_FLAGS:  r = {1'b0, flags_q};
         RA_MASK:   r = {1'b0, mask_q};
         RA_CTRL:   r[PDOWN_BIT] = pdown_q;
         default:   r = 8'h00;
      endcase
      return r;
   endfunction : reg_rd

   // a function result cannot be bit-selected, so the byte is held here
   always_comb begin
      rd_byte = reg_rd(ptr_q);
   end

   mcst_sync #(.W(SYN_W), .RST_VAL(SYN_RST_VAL)) u_sync (
      .clk_i(MCLK_I),
      .arst_n_i(ARST_N_I),
      .d_i({RX_LOS_I, TX_FAULT_I, LOW_POWER_REQUEST_I, MODULE_RESET_N_I,
            MODULE_SELECT_N_I, SDA_I, SCL_I}),
      .q_o(s)
   );

   // reset pin qualification: short glitches never reset
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         lo_cnt_q <= '0;
      end else if (s[SI_RST]) begin
         lo_cnt_q <= '0;
      end else if (lo_cnt_q != RST_CNT_W'(RST_MIN_CYC)) begin
         lo_cnt_q <= lo_cnt_q + 1'b1;
      end
   end
   assign soft_rst = !s[SI_RST] && (lo_cnt_q == RST_CNT_W'(RST_MIN_CYC));

   // timer reloads while reset is held, runs from release and from power up
   mcst_timer #(.W(INIT_W), .LOAD(INIT_W'(INIT_CYC))) u_init (
      .clk_i(MCLK_I),
      .arst_n_i(ARST_N_I),
      .start_i(soft_rst),
      .done_o(init_done)
   );

   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         not_ready_q <= 1'b1;
      end else if (soft_rst) begin
         not_ready_q <= 1'b1;
      end else if (init_done) begin
         not_ready_q <= 1'b0;
      end
   end

   // flag sources
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         los_p_q <= 4'h0;
         txf_p_q <= 1'b0;
      end else begin
         los_p_q <= s[SI_LOS +: 4];
         txf_p_q <= s[SI_TXF];
      end
   end

   always_comb begin
      flag_set.los = s[SI_LOS +: 4] & ~los_p_q;
      flag_set.tx_fault = s[SI_TXF] & ~txf_p_q;
      flag_set.other = ev_stb;
      flag_set.init_done = init_done;
      flag_clr = rd_done && (ptr_q == RA_FLAGS) ? '1 : '0;
   end

   // set wins over clear-on-read so no event is lost
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         flags_q <= '0;
      end else if (soft_rst) begin
         flags_q <= '0;
      end else begin
         flags_q <= (flags_q & ~flag_clr) | flag_set;
      end
   end

   // host settings
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         mask_q <= MASK_RST;
         pdown_q <= PDOWN_RST;
      end else if (soft_rst) begin
         mask_q <= MASK_RST;
         pdown_q <= PDOWN_RST;
      end else if (wr_stb && ptr_q == RA_MASK) begin
         mask_q <= sh_q[6:0];
      end else if (wr_stb && ptr_q == RA_CTRL) begin
         pdown_q <= sh_q[PDOWN_BIT];
      end
   end

   // 2-wire slave, oversampled; scl period is several clocks
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= s[SI_SCL];
         sda_p_q <= s[SI_SDA];
      end
   end
   assign sel = !s[SI_SEL];
   assign scl_rise = s[SI_SCL] && !scl_p_q;
   assign scl_fall = !s[SI_SCL] && scl_p_q;
   assign start_c = s[SI_SCL] && scl_p_q && sda_p_q && !s[SI_SDA];
   assign stop_c = s[SI_SCL] && scl_p_q && !sda_p_q && s[SI_SDA];
   assign wr_stb = sel && scl_fall && st_q == S_WR && bit_q == BITS_PER_BYTE && !first_q;
   assign rd_done = sel && scl_fall && st_q == S_RD && bit_q == BITS_PER_BYTE;

   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         st_q <= S_IDLE;
         sh_q <= 8'h00;
         bit_q <= 4'h0;
         ptr_q <= PTR_RST;
         first_q <= 1'b0;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (!sel) begin
         st_q <= S_IDLE;
         oe_q <= 1'b0;
      end else if (stop_c) begin
         st_q <= S_IDLE;
         oe_q <= 1'b0;
      end else if (start_c) begin
         st_q <= S_ADDR;
         bit_q <= 4'h0;
         first_q <= 1'b1;
         oe_q <= 1'b0;
      end else if (scl_rise) begin
         case (st_q)
            S_ADDR, S_WR: begin
               sh_q <= {sh_q[6:0], s[SI_SDA]};
               bit_q <= bit_q + 1'b1;
            end
            S_RD: bit_q <= bit_q + 1'b1;
            S_RACK: nack_q <= s[SI_SDA];
            default: ;
         endcase
      end else if (scl_fall) begin
         case (st_q)
            S_ADDR: begin
               if (bit_q == BITS_PER_BYTE && sh_q[7:1] == DEV_ADDR) begin
                  st_q <= S_AACK;
                  rw_q <= sh_q[0];
                  oe_q <= 1'b1;
               end else if (bit_q == BITS_PER_BYTE) begin
                  st_q <= S_IDLE;
               end
            end
            S_AACK: begin
               bit_q <= 4'h0;
               if (rw_q) begin
                  sh_q <= rd_byte;
                  oe_q <= !rd_byte[7];
                  st_q <= S_RD;
               end else begin
                  oe_q <= 1'b0;
                  st_q <= S_WR;
               end
            end
            S_WR: begin
               if (bit_q == BITS_PER_BYTE) begin
                  oe_q <= 1'b1;
                  st_q <= S_WACK;
                  first_q <= 1'b0;
                  ptr_q <= first_q ? sh_q : ptr_q + 1'b1;
               end
            end
            S_WACK: begin
               oe_q <= 1'b0;
               bit_q <= 4'h0;
               st_q <= S_WR;
            end
            S_RD: begin
               if (bit_q == BITS_PER_BYTE) begin
                  oe_q <= 1'b0;
                  st_q <= S_RACK;
                  ptr_q <= ptr_q + 1'b1;
               end else begin
                  sh_q <= {sh_q[6:0], 1'b0};
                  oe_q <= !sh_q[6];
               end
            end
            S_RACK: begin
               if (nack_q) begin
                  st_q <= S_IDLE;
               end else begin
                  sh_q <= rd_byte;
                  oe_q <= !rd_byte[7];
                  bit_q <= 4'h0;
                  st_q <= S_RD;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // pin outputs
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         int_n_q <= 1'b1;
         lp_q <= 1'b0;
         zero_q <= 1'b0;
      end else begin
         int_n_q <= ~|(flags_q & ~mask_q);
         lp_q <= s[SI_LP] | pdown_q;
         zero_q <= 1'b0;
      end
   end

   // apb slave, one wait state
   assign ev_stb = PSEL_I && PENABLE_I && pready_q && PWRITE_I
      && PADDR_I == APB_EVENT && PWDATA_I[EV_OTHER_BIT];

   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= PSEL_I && PENABLE_I && !pready_q;
         if (PSEL_I && !PENABLE_I) begin
            pslverr_q <= !((PADDR_I == APB_STATUS && !PWRITE_I)
               || (PADDR_I == APB_EVENT && PWRITE_I));
            prdata_q <= 32'h0000_0000;
            if (PADDR_I == APB_STATUS && !PWRITE_I) begin
               prdata_q[ST_NRDY_LSB] <= not_ready_q;
               prdata_q[ST_LP_LSB] <= lp_q;
               prdata_q[ST_FLAG_LSB +: 7] <= flags_q;
               prdata_q[ST_MASK_LSB +: 7] <= mask_q;
            end
         end
      end
   end

   assign PRDATA_O = prdata_q;
   assign PREADY_O = pready_q;
   assign PSLVERR_O = pslverr_q;
   assign SDA_O = zero_q;
   assign SDA_OE_O = oe_q;
   assign INTERRUPT_OUT_N_O = int_n_q;
   assign PRESENCE_OUT_N_O = zero_q;
   assign LOW_POWER_O = lp_q;

   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!ARST_N_I);

   sequence s_rst_held;
      soft_rst [*2];
   endsequence
   sequence s_not_ready_int_high;
      not_ready_q ##1 int_n_q;
   endsequence
   property p_reset_restart;
      s_rst_held |-> ##1 s_not_ready_int_high;
   endproperty
   a_reset_restart: assert property (p_reset_restart) else $error("reset not restarted");
   property p_defaults;
      soft_rst |=> mask_q == MASK_RST && !pdown_q && flags_q == '0;
   endproperty
   a_defaults: assert property (p_defaults) else $error("settings not defaulted");
   property p_ready;
      init_done && !soft_rst && !mask_q[6] |=> !not_ready_q ##1 !int_n_q;
   endproperty
   a_ready: assert property (p_ready) else $error("ready not signalled");
   property p_los;
      $rose(s[SI_LOS]) && !soft_rst |=> flags_q.los[0] ##[1:2] (mask_q[0] || !int_n_q);
   endproperty
   a_los: assert property (p_los) else $error("los flag late");
   property p_txf;
      $rose(s[SI_TXF]) && !soft_rst |=> flags_q.tx_fault;
   endproperty
   a_txf: assert property (p_txf) else $error("tx fault flag missing");
   property p_other;
      ev_stb && !soft_rst |=> flags_q.other;
   endproperty
   a_other: assert property (p_other) else $error("event flag missing");
   property p_int_follow;
      ##1 int_n_q == ~|($past(flags_q) & ~$past(mask_q));
   endproperty
   a_int_follow: assert property (p_int_follow) else $error("interrupt mismatch");
   property p_release;
      (flags_q & ~mask_q) == '0 [*2] |-> int_n_q;
   endproperty
   a_release: assert property (p_release) else $error("interrupt held");
   property p_desel;
      s[SI_SEL] |=> st_q == S_IDLE && !oe_q;
   endproperty
   a_desel: assert property (p_desel) else $error("answered while deselected");
   property p_lp;
      s[SI_LP] || pdown_q |=> LOW_POWER_O;
   endproperty
   a_lp: assert property (p_lp) else $error("low power late");
endmodule : mcst_top

// ==== verif/mcst_host.sv ====
`timescale 1ns/1ps
module mcst_host
   import mcst_pkg::*;
#(
   parameter logic [6:0] ADDR = DEV_ADDR_DEF
) (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic pull_o
);
   // scl stands high between frames, sda is left to the pull-up
   initial begin
      scl_o = 1'b1;
      pull_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   // sda moves mid low phase, so the slave's synchroniser never sees it race scl
   task automatic clk_bit(input logic d, output logic s);
      scl_o <= 1'b0;
      tick(2);
      pull_o <= !d;
      tick(2);
      scl_o <= 1'b1;
      tick(3);
      s = sda_i;
      tick(1);
   endtask : clk_bit
   task automatic start();
      logic s;
      clk_bit(1'b1, s);
      pull_o <= 1'b1;
      tick(4);
   endtask : start
   task automatic stop();
      logic s;
      clk_bit(1'b0, s);
      pull_o <= 1'b0;
      tick(4);
   endtask : stop
   // ninth clock always released: ack slot on writes, nack ends a read
   task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], s);
         q[i] = s;
      end
      clk_bit(1'b1, s);
      ack = !s;
   endtask : xbyte
   task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic a0, a1, a2;
      start();
      xbyte({ADDR, 1'b0}, q, a0);
      xbyte(p, q, a1);
      xbyte(d, q, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask : wr
   task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic a0, a1, a2, a3;
      start();
      xbyte({ADDR, 1'b0}, q, a0);
      xbyte(p, q, a1);
      start();
      xbyte({ADDR, 1'b1}, q, a2);
      xbyte(8'hFF, d, a3);
      stop();
      ok = a0 & a1 & a2;
   endtask : rd
endmodule : mcst_host

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import mcst_pkg::*;
   localparam int unsigned ICYC = 200;
   localparam logic [7:0] BAD [3] = '{8'h08, APB_STATUS, APB_EVENT};
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic sel_n = 1'b0;
   logic mrst_n = 1'b1;
   logic lpr = 1'b0;
   logic [3:0] los = 4'h0;
   logic txf = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, sda_o, sda_oe, int_n, pres_n, lp, scl, pull;
   wire sda = (pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
   int fails = 0;
   int samples_checked = 0;
   logic [31:0] rv;
   logic [7:0] bv;
   logic ok, er;

   mcst_top #(.INIT_CYC(ICYC)) i_dut (
      .MCLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .SCL_I(scl), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE_O(sda_oe), .MODULE_SELECT_N_I(sel_n),
      .MODULE_RESET_N_I(mrst_n), .LOW_POWER_REQUEST_I(lpr), .RX_LOS_I(los),
      .TX_FAULT_I(txf), .INTERRUPT_OUT_N_O(int_n), .PRESENCE_OUT_N_O(pres_n),
      .LOW_POWER_O(lp)
   );
   mcst_host i_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));

   initial begin
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   // called just after an edge; ends one edge after release so calls never collide
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fails++;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb

   function automatic logic watch(input int k);
      return (k == 0) ? int_n : lp;
   endfunction : watch

   task automatic wait_for(input int k, input logic v, input int lim);
      int n;
      n = 0;
      while (watch(k) !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk(32'(watch(k)), 32'(v));
   endtask : wait_for

   task automatic t_power_on();
      wait_for(0, 1'b0, ICYC + 20);
      chk(32'(pres_n), 32'h0);
      apb(1'b0, APB_STATUS, 32'h0, rv, er);
      chk(32'(rv[NOT_READY_BIT]), 32'h0);
      i_host.rd(RA_STATUS, bv, ok);
      chk(32'({ok, bv[NOT_READY_BIT]}), 32'h2);
      i_host.rd(RA_FLAGS, bv, ok);
      chk(32'(bv), 32'h40);
      wait_for(0, 1'b1, 10000);
      for (int i = 0; i < 3; i++) begin
         apb(i == 1, BAD[i], 32'h0, rv, er);
         chk(32'(er), 32'h1);
      end
      $display("power-on test done");
   endtask : t_power_on

   task automatic t_flags();
      for (int i = 0; i < 6; i++) begin
         if (i < 4) los <= 4'h1 << i;
         else if (i == 4) txf <= 1'b1;
         else apb(1'b1, APB_EVENT, 32'h1, rv, er);
         wait_for(0, 1'b0, 4000);
         apb(1'b0, APB_STATUS, 32'h0, rv, er);
         chk(32'(rv[14:8]), 32'(7'h1 << i));
         i_host.rd(RA_FLAGS, bv, ok);
         chk(32'(bv), 32'(8'h1 << i));
         wait_for(0, 1'b1, 10000);
      end
      los <= 4'h0;
      txf <= 1'b0;
      $display("flag test done");
   endtask : t_flags

   task automatic t_mask();
      i_host.wr(RA_MASK, 8'h10, ok);
      txf <= 1'b1;
      repeat (400) @(posedge clk);
      chk(32'(int_n), 32'h1);
      apb(1'b0, APB_STATUS, 32'h0, rv, er);
      chk(32'(rv[22:8]), 32'h1010);
      i_host.wr(RA_MASK, 8'h00, ok);
      wait_for(0, 1'b0, 2000);
      i_host.rd(RA_FLAGS, bv, ok);
      chk(32'(bv), 32'h10);
      wait_for(0, 1'b1, 10000);
      txf <= 1'b0;
      $display("mask test done");
   endtask : t_mask

   task automatic t_power();
      lpr <= 1'b1;
      wait_for(1, 1'b1, 2000);
      lpr <= 1'b0;
      wait_for(1, 1'b0, 2000);
      i_host.wr(RA_CTRL, 8'h01, ok);
      wait_for(1, 1'b1, 2000);
      apb(1'b0, APB_STATUS, 32'h0, rv, er);
      chk(32'(rv[ST_LP_LSB]), 32'h1);
      i_host.wr(RA_CTRL, 8'h00, ok);
      wait_for(1, 1'b0, 6000);
      $display("power test done");
   endtask : t_power

   task automatic t_select();
      sel_n <= 1'b1;
      repeat (20) @(posedge clk);
      i_host.wr(RA_MASK, 8'h7F, ok);
      chk(32'(ok), 32'h0);
      apb(1'b0, APB_STATUS, 32'h0, rv, er);
      chk(32'(rv[22:16]), 32'h0);
      sel_n <= 1'b0;
      repeat (20) @(posedge clk);
      i_host.rd(RA_MASK, bv, ok);
      chk(32'({ok, bv}), 32'h100);
      $display("select test done");
   endtask : t_select

   task automatic t_modreset();
      i_host.wr(RA_MASK, 8'h05, ok);
      i_host.wr(RA_CTRL, 8'h01, ok);
      mrst_n <= 1'b0;
      repeat (30) @(posedge clk);
      mrst_n <= 1'b1;
      repeat (20) @(posedge clk);
      apb(1'b0, APB_STATUS, 32'h0, rv, er);
      chk(32'(rv[22:0]), 32'h050002);
      mrst_n <= 1'b0;
      repeat (50) @(posedge clk);
      apb(1'b0, APB_STATUS, 32'h0, rv, er);
      chk(32'(rv[22:0]), 32'h000001);
      mrst_n <= 1'b1;
      wait_for(0, 1'b0, ICYC + 20);
      chk(32'(lp), 32'h0);
      i_host.rd(RA_FLAGS, bv, ok);
      chk(32'(bv), 32'h40);
      wait_for(0, 1'b1, 10000);
      $display("module reset test done");
   endtask : t_modreset

   // bound sized well above the sum of all scenarios
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      give_verdict();
   end

   initial begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_power_on();
      t_flags();
      t_mask();
      t_power();
      t_select();
      t_modreset();
      give_verdict();
   end
endmodule : tb_top
